/* core/fvc_regs.sv */
// Function
// - SSO bit clear inverts DQ3 only
// - two bits pick CRC chunk size
// - CRC bit low enables parity in DDR
// - select bit picks detection or correction
// - select bit picks chunk address capture event
// - select bit honoured only with ECC on
// - error pin enable low activates pin
// - ECC enable low turns correction on
// - byte 0Ah holds training pattern, 55h
// - wrap byte: continuous, 64, 32, 16
// - XIP byte FEh enables execute-in-place
// - address width byte picks 3 or 4
// - dummy byte sets fast read dummies
// - mode byte picks SPI or octal DDR
// - DDR-boot parts allow only octal DDR strobe
// - correction counter saturates at fifteen
// - only low address byte selects register
// - reserved address reads back FFh
// - reserved write ignored, flags, clears WEL
`timescale 1ns/10ps
module fvc_regs
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        pin_sclk,
  input  wire logic        pin_cs_n,
  input  wire logic        pin_din,
  input  wire logic        boot_ddr_strap,
  input  wire logic        ecc_correct_evt,
  input  wire logic        ecc_detect_evt,
  input  wire logic [27:0] ecc_chunk_addr,
  input  wire logic        train_active,
  input  wire logic [2:0]  train_bit_idx,
  output logic             pin_dout,
  output logic             pin_dout_oe,
  output logic             err_n,
  output logic [7:0]       train_dq,
  output logic [7:0]       io_protocol_mode,
  output logic             octal_ddr,
  output logic             strobe_enable,
  output logic [4:0]       dummy_cycles,
  output logic             dummy_default,
  output logic             addr_4byte,
  output logic             xip_enable,
  output logic [6:0]       wrap_bytes,
  output logic [7:0]       crc_chunk_bytes,
  output logic             parity_check_en,
  output logic             correction_on,
  output logic [3:0]       correction_event_counter,
  output logic [27:0]      failing_chunk_address,
  output logic             write_enable_latch,
  output logic             reserved_write_flag
);
  import fvc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // link pins: synchronised then edge detected
  logic [2:0] pins_s;
  logic       sclk_d;
  fvc_sync #(.WIDTH(3)) u_sync
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({pin_sclk, pin_cs_n, pin_din}),
    .sync_out (pins_s)
  );
  wire sclk_s    = pins_s[2];
  wire selected  = !pins_s[1];
  wire sclk_rise = sclk_s && !sclk_d;
  wire sclk_fall = !sclk_s && sclk_d;

  logic       [7:0] rx_byte;
  logic             rx_valid;
  logic             tx_load;
  logic       [7:0] tx_byte;
  fvc_shift u_shift
  (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .selected  (selected),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .din       (pins_s[0]),
    .tx_load   (tx_load),
    .tx_byte   (tx_byte),
    .rx_byte   (rx_byte),
    .rx_valid  (rx_valid),
    .dout      (pin_dout)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // configuration bytes
  logic [7:0] mode_r;
  logic [7:0] dummy_r;
  logic [7:0] drive_r;
  logic [7:0] awidth_r;
  logic [7:0] xip_r;
  logic [7:0] wrap_r;
  logic [7:0] pattern_r;
  logic [7:0] integ_r;
  logic       ddr_boot;
  logic       strap_taken;

  fvc_state_t state;
  logic [1:0] addr_cnt;
  logic [7:0] addr_lsb;
  logic       is_read;

  wire       ecc_on    = !integ_r[BIT_ECC_N];
  wire       sel_event = integ_r[BIT_ERR_SEL] ? ecc_detect_evt : ecc_correct_evt;
  wire       ecc_hit   = ecc_on && sel_event;
  wire [1:0] last_addr = awidth_r == SEL_ON ? 2'd3 : 2'd2;

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (a)
      OFS_IO_MODE:    read_byte = mode_r;
      OFS_DUMMY:      read_byte = dummy_r;
      OFS_DRIVE:      read_byte = drive_r;
      OFS_ADDR_WIDTH: read_byte = awidth_r;
      OFS_XIP:        read_byte = xip_r;
      OFS_WRAP:       read_byte = wrap_r;
      OFS_TRAIN:      read_byte = pattern_r;
      OFS_INTEG:      read_byte = integ_r;
      OFS_ECC_STAT:   read_byte = {1'b0, correction_event_counter, 3'b000};
      OFS_FCA_LO:     read_byte = {failing_chunk_address[3:0], 4'h0};
      OFS_FCA_A:      read_byte = failing_chunk_address[11:4];
      OFS_FCA_B:      read_byte = failing_chunk_address[19:12];
      OFS_FCA_HI:     read_byte = failing_chunk_address[27:20];
      default:        read_byte = RD_RESERVED;
    endcase
  endfunction : read_byte

  // legal settings per byte; anything else is a reserved write
  function automatic logic write_legal(input logic [7:0] a, input logic [7:0] d, input logic ddr);
    case (a)
      OFS_IO_MODE:    write_legal = ddr ? (d == MODE_ODDR)
                                        : (d == MODE_XSPI || d == MODE_XSPI_NS ||
                                           d == MODE_ODDR || d == MODE_ODDR_NS);
      OFS_DUMMY:      write_legal = d <= DUMMY_MAX;
      OFS_DRIVE,
      OFS_WRAP:       write_legal = d >= WRAP_16;
      OFS_ADDR_WIDTH,
      OFS_XIP:        write_legal = d >= SEL_ON;
      OFS_TRAIN,
      OFS_INTEG:      write_legal = 1'b1;
      default:        write_legal = 1'b0;
    endcase
  endfunction : write_legal

  wire in_cmd   = state == ST_CMD;
  wire in_addr  = state == ST_ADDR;
  wire addr_end = rx_valid && in_addr && (addr_cnt == last_addr);
  wire cmd_seen = rx_valid && in_cmd;
  wire do_write = rx_valid && (state == ST_DIN) && write_enable_latch;
  wire legal    = write_legal(addr_lsb, rx_byte, ddr_boot);
  wire wr_ok    = do_write && legal;
  wire sw_reset = cmd_seen && (rx_byte == CMD_SW_RESET);
  wire [7:0] flag_byte = {1'b1, 5'b00000, reserved_write_flag, 1'b0};

  assign tx_load = (cmd_seen && rx_byte == CMD_RD_FLAG) || (addr_end && is_read) ||
                   (rx_valid && state == ST_DOUT);
  assign tx_byte = (in_cmd || (state == ST_DOUT && !is_read)) ? flag_byte :
                   in_addr ? read_byte(rx_byte) : read_byte(addr_lsb);

  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer
  fvc_state_t next_state;
  always_comb
  begin
    next_state = state;
    if (!selected)
      next_state = ST_CMD;
    else if (rx_valid)
      case (state)
        ST_CMD:
          case (rx_byte)
            CMD_WR_CFG,
            CMD_RD_CFG:  next_state = ST_ADDR;
            CMD_RD_FLAG: next_state = ST_DOUT;
            default:     next_state = ST_SKIP;
          endcase
        ST_ADDR: next_state = addr_end ? (is_read ? ST_DOUT : ST_DIN) : ST_ADDR;
        ST_DIN:  next_state = ST_SKIP;
        ST_DOUT: next_state = ST_DOUT;
        ST_SKIP: next_state = ST_SKIP;
        default: next_state = ST_CMD;
      endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= ST_CMD;
      sclk_d   <= 1'b1;
      addr_cnt <= 2'd0;
      addr_lsb <= 8'h00;
      is_read  <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      sclk_d <= sclk_s;
      if (cmd_seen)
      begin
        is_read  <= rx_byte == CMD_RD_CFG;
        addr_cnt <= 2'd0;
      end
      else if (rx_valid && in_addr)
      begin
        addr_cnt <= addr_cnt + 2'd1;
        addr_lsb <= rx_byte;
      end
    end
  end

  // strap caught on the first clock after reset release, never under reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_taken <= 1'b0;
      ddr_boot    <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      ddr_boot    <= boot_ddr_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes; software reset reloads the same defaults as the pin
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r    <= RST_ERASED;
      dummy_r   <= RST_DUMMY;
      drive_r   <= RST_ERASED;
      awidth_r  <= RST_ERASED;
      xip_r     <= RST_ERASED;
      wrap_r    <= RST_ERASED;
      pattern_r <= RST_TRAIN;
      integ_r   <= RST_ERASED;
    end
    else if (sw_reset)
    begin
      mode_r    <= RST_ERASED;
      dummy_r   <= RST_DUMMY;
      drive_r   <= RST_ERASED;
      awidth_r  <= RST_ERASED;
      xip_r     <= RST_ERASED;
      wrap_r    <= RST_ERASED;
      pattern_r <= RST_TRAIN;
      integ_r   <= RST_ERASED;
    end
    else if (wr_ok)
      case (addr_lsb)
        OFS_IO_MODE:    mode_r    <= rx_byte;
        OFS_DUMMY:      dummy_r   <= rx_byte;
        OFS_DRIVE:      drive_r   <= rx_byte;
        OFS_ADDR_WIDTH: awidth_r  <= rx_byte;
        OFS_XIP:        xip_r     <= rx_byte;
        OFS_WRAP:       wrap_r    <= rx_byte;
        OFS_TRAIN:      pattern_r <= rx_byte;
        default:        integ_r   <= rx_byte | 8'h80; // bit 7 stays reserved
      endcase
  end

  // write latch and flag: a reserved write sets the flag even if a clear arrives
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_enable_latch  <= 1'b0;
      reserved_write_flag <= 1'b0;
    end
    else
    begin
      if (do_write || (cmd_seen && rx_byte == CMD_WRDI) || sw_reset)
        write_enable_latch <= 1'b0;
      else if (cmd_seen && rx_byte == CMD_WREN)
        write_enable_latch <= 1'b1;
      if (do_write && !legal)
        reserved_write_flag <= 1'b1;
      else if (cmd_seen && (rx_byte == CMD_CLR_FLAG || rx_byte == CMD_SW_RESET))
        reserved_write_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ECC events, error pin held low until the next command byte is received
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      err_n                    <= 1'b1;
      correction_event_counter <= 4'h0;
      failing_chunk_address    <= 28'h0000000;
    end
    else
    begin
      if (ecc_hit && !integ_r[BIT_ERRPIN_N])
        err_n <= 1'b0;
      else if (cmd_seen || integ_r[BIT_ERRPIN_N])
        err_n <= 1'b1;
      if (ecc_hit)
        failing_chunk_address <= ecc_chunk_addr;
      if (ecc_on && ecc_correct_evt && correction_event_counter != CNT_SAT)
        correction_event_counter <= correction_event_counter + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decoded settings, registered so every output leaves a flop
  wire [7:0] sso_mask = integ_r[BIT_SSO_N] ? 8'h00 : SSO_INVERT_MASK;
  wire       pat_bit  = pattern_r[3'd7 - train_bit_idx];
  wire       mode_ddr = (mode_r == MODE_ODDR) || (mode_r == MODE_ODDR_NS);
  wire [1:0] crc_sel  = integ_r[BIT_CRC_HI:BIT_CRC_LO];

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_dout_oe      <= 1'b0;
      train_dq         <= 8'h00;
      io_protocol_mode <= RST_ERASED;
      octal_ddr        <= 1'b0;
      strobe_enable    <= 1'b1;
      dummy_cycles     <= 5'h1F;
      dummy_default    <= 1'b1;
      addr_4byte       <= 1'b0;
      xip_enable       <= 1'b0;
      wrap_bytes       <= 7'h00;
      crc_chunk_bytes  <= 8'h10;
      parity_check_en  <= 1'b0;
      correction_on    <= 1'b0;
    end
    else
    begin
      pin_dout_oe      <= selected && state == ST_DOUT;
      train_dq         <= train_active ? ({8{pat_bit}} ^ sso_mask) : 8'h00;
      io_protocol_mode <= mode_r;
      octal_ddr        <= mode_ddr;
      strobe_enable    <= mode_r == MODE_XSPI || mode_r == MODE_ODDR;
      dummy_cycles     <= dummy_r[4:0];
      dummy_default    <= dummy_r == DUMMY_MAX || dummy_r == DUMMY_ZERO;
      addr_4byte       <= awidth_r == SEL_ON;
      xip_enable       <= xip_r == SEL_ON;
      wrap_bytes       <= wrap_r == WRAP_64 ? 7'd64 : wrap_r == WRAP_32 ? 7'd32 :
                          wrap_r == WRAP_16 ? 7'd16 : 7'd0;
      crc_chunk_bytes  <= 8'h10 << (2'd3 - crc_sel);
      parity_check_en  <= !integ_r[BIT_CRC_N] && mode_ddr;
      correction_on    <= ecc_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_sso;
    @(posedge mclk) disable iff (!reset_n)
    train_active |=> (train_dq[3] ^ train_dq[2]) == !integ_r[BIT_SSO_N];
  endproperty
  a_sso: assert property (p_sso) else $error("dq3 inversion wrong");

  property p_crc_size;
    @(posedge mclk) disable iff (!reset_n)
    (crc_sel == 2'b00) |=> crc_chunk_bytes == 8'h80 || $past(crc_sel) != 2'b00;
  endproperty
  a_crc_size: assert property (p_crc_size) else $error("crc chunk size wrong");

  property p_parity;
    @(posedge mclk) disable iff (!reset_n)
    parity_check_en |-> $past(mode_ddr) && !$past(integ_r[BIT_CRC_N]);
  endproperty
  a_parity: assert property (p_parity) else $error("parity on outside ddr");

  property p_err_low;
    @(posedge mclk) disable iff (!reset_n)
    $fell(err_n) |-> $past(ecc_on) && $past(sel_event) && !$past(integ_r[BIT_ERRPIN_N]);
  endproperty
  a_err_low: assert property (p_err_low) else $error("error pin fell without cause");

  property p_fca;
    @(posedge mclk) disable iff (!reset_n)
    (ecc_correct_evt && !ecc_detect_evt && integ_r[BIT_ERR_SEL]) |=> $stable(failing_chunk_address);
  endproperty
  a_fca: assert property (p_fca) else $error("address captured on wrong event");

  property p_ecc_off;
    @(posedge mclk) disable iff (!reset_n)
    !ecc_on ##1 !ecc_on |-> $stable(correction_event_counter) && $stable(failing_chunk_address);
  endproperty
  a_ecc_off: assert property (p_ecc_off) else $error("ecc state moved while off");

  property p_sat;
    @(posedge mclk) disable iff (!reset_n)
    correction_event_counter == CNT_SAT |=> correction_event_counter == CNT_SAT || $past(sw_reset);
  endproperty
  a_sat: assert property (p_sat) else $error("counter left saturation");

  property p_reserved;
    @(posedge mclk) disable iff (!reset_n)
    (do_write && !legal) |=> reserved_write_flag && !write_enable_latch ##0 $stable(mode_r);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved write not handled");

  property p_ddr_boot;
    @(posedge mclk) disable iff (!reset_n)
    (ddr_boot && wr_ok && addr_lsb == OFS_IO_MODE) |=> mode_r == MODE_ODDR;
  endproperty
  a_ddr_boot: assert property (p_ddr_boot) else $error("ddr boot part left octal ddr");

endmodule : fvc_regs

/* core/fvc_pkg.sv */
package fvc_pkg;

  // register byte addresses, low address byte only
  localparam logic [7:0] OFS_IO_MODE    = 8'h00;
  localparam logic [7:0] OFS_DUMMY      = 8'h01;
  localparam logic [7:0] OFS_DRIVE      = 8'h03;
  localparam logic [7:0] OFS_ADDR_WIDTH = 8'h05;
  localparam logic [7:0] OFS_XIP        = 8'h06;
  localparam logic [7:0] OFS_WRAP       = 8'h07;
  localparam logic [7:0] OFS_TRAIN      = 8'h0A;
  localparam logic [7:0] OFS_INTEG      = 8'h0B;
  localparam logic [7:0] OFS_ECC_STAT   = 8'h0C;
  localparam logic [7:0] OFS_FCA_LO     = 8'h0D;
  localparam logic [7:0] OFS_FCA_A      = 8'h0E;
  localparam logic [7:0] OFS_FCA_B      = 8'h0F;
  localparam logic [7:0] OFS_FCA_HI     = 8'h10;

  // reset values
  localparam logic [7:0] RST_ERASED     = 8'hFF;
  localparam logic [7:0] RST_DUMMY      = 8'h1F;
  localparam logic [7:0] RST_TRAIN      = 8'h55;
  localparam logic [7:0] RD_RESERVED    = 8'hFF;

  // setting encodings
  localparam logic [7:0] MODE_XSPI      = 8'hFF;
  localparam logic [7:0] MODE_XSPI_NS   = 8'hDF;
  localparam logic [7:0] MODE_ODDR      = 8'hE7;
  localparam logic [7:0] MODE_ODDR_NS   = 8'hC7;
  localparam logic [7:0] SEL_OFF        = 8'hFF;
  localparam logic [7:0] SEL_ON         = 8'hFE;
  localparam logic [7:0] WRAP_64        = 8'hFE;
  localparam logic [7:0] WRAP_32        = 8'hFD;
  localparam logic [7:0] WRAP_16        = 8'hFC;
  localparam logic [7:0] DUMMY_MAX      = 8'h1F;
  localparam logic [7:0] DUMMY_ZERO     = 8'h00;

  // integrity control field positions
  localparam int BIT_SSO_N    = 6;
  localparam int BIT_CRC_HI   = 5;
  localparam int BIT_CRC_LO   = 4;
  localparam int BIT_CRC_N    = 3;
  localparam int BIT_ERR_SEL  = 2;
  localparam int BIT_ERRPIN_N = 1;
  localparam int BIT_ECC_N    = 0;
  localparam logic [7:0] SSO_INVERT_MASK = 8'h08;
  localparam logic [3:0] CNT_SAT         = 4'hF;

  // serial commands
  localparam logic [7:0] CMD_WREN     = 8'h06;
  localparam logic [7:0] CMD_WRDI     = 8'h04;
  localparam logic [7:0] CMD_WR_CFG   = 8'h81;
  localparam logic [7:0] CMD_RD_CFG   = 8'h85;
  localparam logic [7:0] CMD_RD_FLAG  = 8'h70;
  localparam logic [7:0] CMD_CLR_FLAG = 8'h50;
  localparam logic [7:0] CMD_SW_RESET = 8'h99;

  typedef enum logic [4:0]
  {
    ST_CMD  = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DIN  = 5'b00100,
    ST_DOUT = 5'b01000,
    ST_SKIP = 5'b10000
  } fvc_state_t;

endpackage : fvc_pkg

/* core/fvc_sync.sv */
`timescale 1ns/10ps
module fvc_sync
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import fvc_pkg::*;

  logic [WIDTH-1:0] stage1;

  // two flops per line; stage1 feeds only stage2
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          stage1[gi]   <= 1'b1;
          sync_out[gi] <= 1'b1;
        end
        else
        begin
          stage1[gi]   <= async_in[gi];
          sync_out[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

endmodule : fvc_sync

/* core/fvc_shift.sv */
`timescale 1ns/10ps
module fvc_shift
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       selected,
  input  wire logic       sclk_rise,
  input  wire logic       sclk_fall,
  input  wire logic       din,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            dout
);
  import fvc_pkg::*;

  logic [2:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  wire  [7:0] rx_next = {rx_shift[6:0], din};

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt  <= 3'h0;
      rx_shift <= 8'h00;
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= selected && sclk_rise && (bit_cnt == 3'h7);
      if (!selected)
        bit_cnt <= 3'h0;
      else if (sclk_rise)
      begin
        bit_cnt  <= bit_cnt + 3'h1;
        rx_shift <= rx_next;
        if (bit_cnt == 3'h7)
          rx_byte <= rx_next;
      end
    end
  end

  // msb first, driven on the falling edge so it is stable at the host's rising edge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_shift <= 8'h00;
      dout     <= 1'b0;
    end
    else if (tx_load)
      tx_shift <= tx_byte;
    else if (selected && sclk_fall)
    begin
      dout     <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

endmodule : fvc_shift

/* tb/fvc_host.sv */
`timescale 1ns/10ps
module fvc_host
(
  input  wire logic mclk,
  input  wire logic pin_dout,
  input  wire logic pin_dout_oe,
  output logic      pin_sclk,
  output logic      pin_cs_n,
  output logic      pin_din
);
  // link clock idles low between frames, mode 0
  initial
  begin
    pin_sclk = 1'b0;
    pin_cs_n = 1'b1;
    pin_din  = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge mclk);
    #1;
  endtask : half
  // bytes out msb first, then nrd bytes shifted back in
  task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx);
    @(posedge mclk);
    #1;
    pin_cs_n = 1'b0;
    foreach (tx[i])
      for (int b = 7; b >= 0; b--)
      begin
        pin_din = tx[i][b];
        half();
        pin_sclk = 1'b1;
        half();
        pin_sclk = 1'b0;
      end
    for (int b = 0; b < 8 * nrd; b++)
    begin
      half();
      pin_sclk = 1'b1;
      // sampled at the end of the high phase, where the bit has settled
      half();
      // an undriven line reads as the inverse, so a missing enable shows up
      rx = {rx[6:0], pin_dout_oe ? pin_dout : ~pin_dout};
      pin_sclk = 1'b0;
    end
    half();
    pin_cs_n = 1'b1;
    // a released line shows the inverse, never a stale bit
    pin_din = ~pin_din;
    half();
    half();
  endtask : frame
endmodule : fvc_host

/* tb/tb_flash_volatile_config_regs.sv */
`timescale 1ns/10ps
module tb_flash_volatile_config_regs;
  import fvc_pkg::*;
  logic mclk, reset_n, pin_sclk, pin_cs_n, pin_din, pin_dout, pin_dout_oe, err_n, boot_ddr_strap;
  logic ecc_correct_evt, ecc_detect_evt, train_active, octal_ddr, strobe_enable, dummy_default;
  logic addr_4byte, xip_enable, parity_check_en, correction_on, write_enable_latch, reserved_write_flag;
  logic [2:0]  train_bit_idx;
  logic [3:0]  correction_event_counter;
  logic [4:0]  dummy_cycles;
  logic [6:0]  wrap_bytes;
  logic [7:0]  train_dq, io_protocol_mode, crc_chunk_bytes, r;
  logic [27:0] ecc_chunk_addr, failing_chunk_address;
  int          num_errors = 0;
  int          tests_run = 0;
  int          nadr = 3;
  fvc_regs fvc_regs_inst (.mclk, .reset_n, .pin_sclk, .pin_cs_n, .pin_din, .boot_ddr_strap,
    .ecc_correct_evt, .ecc_detect_evt, .ecc_chunk_addr, .train_active, .train_bit_idx, .pin_dout,
    .pin_dout_oe, .err_n, .train_dq, .io_protocol_mode, .octal_ddr, .strobe_enable, .dummy_cycles,
    .dummy_default, .addr_4byte, .xip_enable, .wrap_bytes, .crc_chunk_bytes, .parity_check_en,
    .correction_on, .correction_event_counter, .failing_chunk_address, .write_enable_latch,
    .reserved_write_flag);
  fvc_host fvc_host_inst (.mclk, .pin_dout, .pin_dout_oe, .pin_sclk, .pin_cs_n, .pin_din);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // upper address bytes are nonzero, so only the low byte may select
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q[$];
    fvc_host_inst.frame({CMD_WREN}, 0, r);
    q = {CMD_WR_CFG};
    repeat (nadr - 1) q.push_back(8'h5A);
    q.push_back(a);
    q.push_back(d);
    fvc_host_inst.frame(q, 0, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q[$];
    q = {CMD_RD_CFG};
    repeat (nadr - 1) q.push_back(8'hA5);
    q.push_back(a);
    fvc_host_inst.frame(q, 1, r);
    check(r, e);
  endtask : rd
  task automatic evt(input logic det, input logic [27:0] a);
    @(posedge mclk);
    #1;
    ecc_correct_evt = !det;
    ecc_detect_evt = det;
    ecc_chunk_addr = a;
    @(posedge mclk);
    #1;
    ecc_correct_evt = 1'b0;
    ecc_detect_evt = 1'b0;
    @(posedge mclk);
    #1;
  endtask : evt
  ////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0] a[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h40};
    logic [7:0] e[9] = '{8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h55, 8'hFF};
    foreach (a[i])
      rd(a[i], e[i]);
    check({crc_chunk_bytes, correction_on, err_n, xip_enable}, {8'd16, 3'b010});
  endtask : t_defaults
  task automatic t_modes();
    logic [7:0] m[4] = '{8'hDF, 8'hE7, 8'hC7, 8'hFF};
    logic [1:0] e[4] = '{2'b00, 2'b11, 2'b10, 2'b01};
    foreach (m[i])
    begin
      wr(OFS_IO_MODE, m[i]);
      check({octal_ddr, strobe_enable}, e[i]);
    end
    wr(OFS_IO_MODE, 8'h12);
    check({io_protocol_mode, write_enable_latch, reserved_write_flag}, 10'h3FD);
    fvc_host_inst.frame({CMD_RD_FLAG}, 1, r);
    check(r, 8'h82);
    fvc_host_inst.frame({CMD_CLR_FLAG}, 0, r);
  endtask : t_modes
  task automatic t_settings();
    logic [7:0] w[3] = '{8'hFE, 8'hFD, 8'hFC};
    wr(OFS_ADDR_WIDTH, 8'hFE);
    nadr = 4;
    check(addr_4byte, 1'b1);
    rd(OFS_ADDR_WIDTH, 8'hFE);
    wr(OFS_ADDR_WIDTH, 8'hFF);
    nadr = 3;
    check(addr_4byte, 1'b0);
    wr(OFS_XIP, 8'hFE);
    check(xip_enable, 1'b1);
    foreach (w[i])
    begin
      wr(OFS_WRAP, w[i]);
      check(wrap_bytes, 7'd64 >> i);
    end
    wr(OFS_DUMMY, 8'h00);
    check(dummy_default, 1'b1);
    wr(OFS_DUMMY, 8'h1E);
    check({dummy_default, dummy_cycles}, 6'd30);
    wr(OFS_TRAIN, 8'hAA);
    rd(OFS_TRAIN, 8'hAA);
  endtask : t_settings
  task automatic t_integ();
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_INTEG, 8'(8'hCF | (s << 4)));
      check(crc_chunk_bytes, 8'd128 >> s);
    end
    wr(OFS_INTEG, 8'hC7);
    check(parity_check_en, 1'b0);
    wr(OFS_IO_MODE, MODE_ODDR);
    check(parity_check_en, 1'b1);
    wr(OFS_IO_MODE, MODE_XSPI);
    wr(OFS_INTEG, 8'hFC);
    evt(1'b0, 28'h0000AB0);
    check({correction_on, err_n, correction_event_counter}, 6'h31);
    evt(1'b1, 28'h1234567);
    check({err_n, failing_chunk_address}, {1'b0, 28'h1234567});
    repeat (16) evt(1'b0, 28'h0000001);
    check(correction_event_counter, 4'hF);
    // correction now selected; the write itself releases the pin
    wr(OFS_INTEG, 8'hF8);
    evt(1'b0, 28'h0000456);
    evt(1'b1, 28'h0000789);
    check({err_n, failing_chunk_address}, {1'b0, 28'h0000456});
    wr(OFS_INTEG, 8'hFA);
    evt(1'b0, 28'h0000321);
    check(err_n, 1'b1);
    wr(OFS_INTEG, 8'hF9);
    evt(1'b0, 28'h0000654);
    check({correction_on, err_n, failing_chunk_address}, {2'b01, 28'h0000321});
  endtask : t_integ
  task automatic t_train();
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_INTEG, s ? 8'hFF : 8'hBF);
      train_active = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
        train_bit_idx = 3'(i);
        repeat (2) @(posedge mclk);
        #1;
        check(train_dq, {8{~i[0]}} ^ (s ? 8'h00 : 8'h08));
      end
      train_active = 1'b0;
    end
  endtask : t_train
  task automatic t_soft_reset();
    wr(OFS_IO_MODE, 8'h12);
    fvc_host_inst.frame({CMD_WREN}, 0, r);
    fvc_host_inst.frame({CMD_SW_RESET}, 0, r);
    check({write_enable_latch, reserved_write_flag}, 2'b00);
    t_defaults();
  endtask : t_soft_reset
  // second reset with the octal boot strap set: only octal ddr with strobe is accepted
  task automatic t_ddr_boot();
    @(posedge mclk);
    #1;
    reset_n = 1'b0;
    boot_ddr_strap = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    check({io_protocol_mode, correction_event_counter}, 12'hFF0);
    wr(OFS_IO_MODE, MODE_XSPI_NS);
    check({io_protocol_mode, reserved_write_flag}, 9'h1FF);
    wr(OFS_IO_MODE, MODE_ODDR_NS);
    check(io_protocol_mode, 8'hFF);
    wr(OFS_IO_MODE, MODE_ODDR);
    check({io_protocol_mode, octal_ddr, strobe_enable}, 10'h39F);
  endtask : t_ddr_boot
  ////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    reset_n = 1'b0;
    boot_ddr_strap = 1'b0;
    ecc_correct_evt = 1'b0;
    ecc_detect_evt = 1'b0;
    ecc_chunk_addr = '0;
    train_active = 1'b0;
    train_bit_idx = '0;
    repeat (6) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    t_defaults();
    t_modes();
    t_settings();
    t_integ();
    t_train();
    t_soft_reset();
    t_ddr_boot();
    complete_run();
  end
  // about 20k cycles expected; the limit leaves headroom
  initial
  begin
    #1_000_000;
    num_errors++;
    complete_run();
  end
endmodule : tb_flash_volatile_config_regs
